// *** hw/sync_flash_params.svh ***
/*
 * constants for the synchronous flash bus interface: widths, commands, codes, timing.
 * assumes a 40 MHz ref_clk; included by the package and the design file.
 */
`ifndef SYNC_FLASH_PARAMS_SVH
`define SYNC_FLASH_PARAMS_SVH

// ==========================================================
// widths
`define ADDR_W          21
`define DATA_W          16
`define BLK_W           4
`define BLK_LSB         17
`define CNT_W           12

// ==========================================================
// command codes, low byte of the data lanes
`define CMD_READ_ARRAY  8'hff
`define CMD_READ_ID     8'h90
`define CMD_READ_STATUS 8'h70
`define CMD_CLR_STATUS  8'h50
`define CMD_WRITE       8'h40
`define CMD_WRITE_ALT   8'h10
`define CMD_ERASE       8'h20
`define CMD_CONFIRM     8'hd0
`define CMD_SUSPEND     8'hb0

// ==========================================================
// identifier codes (arbitrary neutral values)
`define MFG_CODE        16'h00a5
`define DEV_CODE        16'h5a3c

// ==========================================================
// timing: operation times in ns, cycles derived from the clock period
`define CLK_PERIOD_NS   25
`define PROG_TIME_NS    1000
`define ERASE_TIME_NS   100000
`define PROG_CYCLES     ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYCLES    ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** hw/sync_flash_pkg.sv ***
/*
 * types of the synchronous flash bus interface: state enums and the state struct.
 * assumes sync_flash_params.svh is on the include path.
 */
`include "sync_flash_params.svh"

package sync_flash_pkg;

    // ==========================================================
    // write state machine and read mode
    typedef enum logic [2:0] {WS_IDLE, WS_PROG_SETUP, WS_ERASE_SETUP, WS_BUSY, WS_SUSPEND} wsm_t;
    typedef enum logic [1:0] {RM_ARRAY, RM_ID, RM_STATUS} read_mode_t;

    // ==========================================================
    // whole module state
    typedef struct packed {
        wsm_t                  wsm_ff;        // write state machine
        read_mode_t            mode_ff;       // what a read returns
        logic                  erase_op_ff;   // current op is an erase
        logic [`CNT_W-1:0]     busy_cnt_ff;   // cycles left in the op
        logic                  we_prev_ff;    // last write strobe sample
        logic                  wp_ff;         // write-protect buffer
        logic                  fault_ff;      // write refused by lock
        logic [`ADDR_W-1:0]    rd_addr_ff;    // latched read address
        logic [`DATA_W-1:0]    dq_out_ff;     // data lane drive value
        logic                  lower_oe_n_ff; // low lanes enable
        logic                  upper_oe_n_ff; // high lanes enable
        logic                  rb_oe_n_ff;    // ready/busy pull-down
        logic [`ADDR_W-1:0]    arr_addr_ff;   // array core address
        logic [`DATA_W-1:0]    arr_wdata_ff;  // array write data
        logic                  arr_wr_ff;     // array program pulse
        logic                  arr_erase_ff;  // block erase pulse
    } state_t;

endpackage

// *** hw/sync_flash_bus_interface.sv ***
/*
 * bus interface of a synchronous flash: clocked read address latch, command
 * decode on the write strobe, write state machine timing, lock protection
 * and the ready/busy pin.
 * assumes all pins are synchronous to ref_clk and the array core answers
 * arr_rdata combinationally for arr_addr.
 */
// Notes on behaviour
// RL1: strobe low at edge latches read address
// RL2: stopped clock loses no data or sync
// RL3: writes run from the write strobe
// RL4: address strobe ignored while writing
// RL5: ready/busy low while machine busy
// RL6: ready/busy released when ready, suspended, powered-down
// RL7: ready/busy independent of enables and selects
// RL8: protect low blocks locked blocks
// RL9: protect high allows every block
// RL10: protect buffer off in power-down
// RL11: width low is byte mode, low lanes
// RL12: width high is word mode, byte select off
// RL13: strobe high latches no new address
// RL14: read drives data when selected and enabled
// RL15: lanes float when disabled or powered-down
// RL16: host writes by pulsing write strobe low
// RL17: power-down aborts, resets, returns to ready
// RL18: selected only while both selects low
// RL19: address and data taken on strobe rise
// RL20: identifier read gives maker or device code
`timescale 1ns/1ps
`default_nettype none
`include "sync_flash_params.svh"

module sync_flash_bus_interface (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    // host control pins
    input  wire logic                  powerdown_reset_n,
    input  wire logic                  chip_select0_n,
    input  wire logic                  chip_select1_n,
    input  wire logic                  output_enable_n,
    input  wire logic                  write_strobe_n,
    input  wire logic                  address_strobe_n,
    input  wire logic                  width_select,
    input  wire logic                  write_protect_n,
    input  wire logic [`ADDR_W-1:0]    addr,
    // data lanes, split into in, out and enables
    input  wire logic [`DATA_W-1:0]    data_in,
    output logic      [`DATA_W-1:0]    data_out,
    output logic                       lower_data_lanes_oe_n,
    output logic                       upper_data_lanes_oe_n,
    // open-drain ready/busy
    output logic                       ready_busy_n_out,
    output logic                       ready_busy_n_oe_n,
    // array core
    input  wire logic [`DATA_W-1:0]    arr_rdata,
    input  wire logic [15:0]           block_lock_status_bit,
    output logic      [`ADDR_W-1:0]    arr_addr,
    output logic      [`DATA_W-1:0]    arr_wdata,
    output logic                       arr_wr,
    output logic                       arr_erase,
    output logic                       write_fault
);

    // ==========================================================
    // state
    sync_flash_pkg::state_t st_ff;  // registered state
    sync_flash_pkg::state_t nxt_st; // next state
    logic                   sel;    // device selected
    logic                   we_rise;// write strobe rising edge
    logic                   blocked;// target block protected
    logic [`BLK_W-1:0]      blk;    // target block of the write

    // reset image shared by nrst and power-down
    function automatic sync_flash_pkg::state_t idle_state();
        sync_flash_pkg::state_t s;
        s               = '0;
        s.wsm_ff        = sync_flash_pkg::WS_IDLE;
        s.mode_ff       = sync_flash_pkg::RM_ARRAY;
        s.we_prev_ff    = 1'b1;
        s.lower_oe_n_ff = 1'b1;
        s.upper_oe_n_ff = 1'b1;
        s.rb_oe_n_ff    = 1'b1;
        return s;
    endfunction

    // pick high or low byte onto the low lanes in byte mode
    function automatic logic [`DATA_W-1:0] lane_fit(input logic [`DATA_W-1:0] w,
                                                    input logic wide, input logic hi);
        if (wide)
            lane_fit = w;
        else
            lane_fit = {8'h00, (hi ? w[15:8] : w[7:0])};
    endfunction

    // byte select buffer is off in word mode, so bit 0 reads as zero there
    function automatic logic [`ADDR_W-1:0] word_align(input logic [`ADDR_W-1:0] a,
                                                      input logic wide);
        word_align = {a[`ADDR_W-1:1], a[0] && !wide}; // [RL12]
    endfunction

    assign sel     = !chip_select0_n && !chip_select1_n; // [RL18]
    assign we_rise = sel && !st_ff.we_prev_ff && write_strobe_n; // [RL19]
    assign blk     = addr[`BLK_LSB +: `BLK_W];
    // locks only bite while the protect buffer reads low
    assign blocked = !st_ff.wp_ff && block_lock_status_bit[blk]; // [RL8] [RL9]

    // ==========================================================
    // next state
    always_comb
    begin
        nxt_st              = st_ff;
        nxt_st.arr_wr_ff    = 1'b0;
        nxt_st.arr_erase_ff = 1'b0;
        nxt_st.we_prev_ff   = write_strobe_n;
        if (!powerdown_reset_n)
        begin
            // abort everything, float lanes, release busy, protect buffer off
            nxt_st = idle_state(); // [RL17] [RL10] [RL15] [RL6]
        end
        else
        begin
            nxt_st.wp_ff = write_protect_n;
            // read address latch only outside write cycles
            if (sel && write_strobe_n && !address_strobe_n) // [RL1] [RL4] [RL13] [RL3]
                nxt_st.rd_addr_ff = word_align(addr, width_select); // [RL12]
            // op timing; a stopped clock just holds the count
            if (st_ff.wsm_ff == sync_flash_pkg::WS_BUSY) // [RL2]
            begin
                if (st_ff.busy_cnt_ff <= `CNT_W'(1))
                    nxt_st.wsm_ff = sync_flash_pkg::WS_IDLE;
                else
                    nxt_st.busy_cnt_ff = st_ff.busy_cnt_ff - `CNT_W'(1);
            end
            // command decode on the write strobe rising edge
            if (we_rise) // [RL19] [RL16]
            begin
                nxt_st.arr_addr_ff  = word_align(addr, width_select); // [RL12]
                nxt_st.arr_wdata_ff = width_select ? data_in : {8'h00, data_in[7:0]};
                case (st_ff.wsm_ff)
                    sync_flash_pkg::WS_IDLE, sync_flash_pkg::WS_SUSPEND:
                    begin
                        case (data_in[7:0])
                            `CMD_READ_ARRAY:  nxt_st.mode_ff = sync_flash_pkg::RM_ARRAY;
                            `CMD_READ_ID:     nxt_st.mode_ff = sync_flash_pkg::RM_ID;
                            `CMD_READ_STATUS: nxt_st.mode_ff = sync_flash_pkg::RM_STATUS;
                            `CMD_CLR_STATUS:  nxt_st.fault_ff = 1'b0;
                            `CMD_WRITE, `CMD_WRITE_ALT:
                                nxt_st.wsm_ff = sync_flash_pkg::WS_PROG_SETUP;
                            `CMD_ERASE:
                                nxt_st.wsm_ff = sync_flash_pkg::WS_ERASE_SETUP;
                            `CMD_CONFIRM:
                                // resume a suspended erase with its count
                                if (st_ff.wsm_ff == sync_flash_pkg::WS_SUSPEND)
                                    nxt_st.wsm_ff = sync_flash_pkg::WS_BUSY;
                            default: ;
                        endcase
                    end
                    sync_flash_pkg::WS_PROG_SETUP, sync_flash_pkg::WS_ERASE_SETUP:
                    begin
                        nxt_st.mode_ff = sync_flash_pkg::RM_STATUS;
                        if (st_ff.wsm_ff == sync_flash_pkg::WS_ERASE_SETUP &&
                            data_in[7:0] != `CMD_CONFIRM)
                            nxt_st.wsm_ff = sync_flash_pkg::WS_IDLE;
                        else if (blocked) // [RL8]
                        begin
                            nxt_st.fault_ff = 1'b1;
                            nxt_st.wsm_ff   = sync_flash_pkg::WS_IDLE;
                        end
                        else
                        begin
                            nxt_st.wsm_ff      = sync_flash_pkg::WS_BUSY;
                            nxt_st.erase_op_ff = (st_ff.wsm_ff == sync_flash_pkg::WS_ERASE_SETUP);
                            nxt_st.arr_erase_ff = nxt_st.erase_op_ff;
                            nxt_st.arr_wr_ff    = !nxt_st.erase_op_ff;
                            nxt_st.busy_cnt_ff  = nxt_st.erase_op_ff ? `CNT_W'(`ERASE_CYCLES)
                                                                     : `CNT_W'(`PROG_CYCLES);
                        end
                    end
                    sync_flash_pkg::WS_BUSY:
                    begin
                        // only an erase may be suspended
                        if (data_in[7:0] == `CMD_SUSPEND && st_ff.erase_op_ff)
                            nxt_st.wsm_ff = sync_flash_pkg::WS_SUSPEND;
                        nxt_st.mode_ff = sync_flash_pkg::RM_STATUS;
                    end
                    default: nxt_st.wsm_ff = sync_flash_pkg::WS_IDLE;
                endcase
            end
            else if (sel && write_strobe_n)
                nxt_st.arr_addr_ff = st_ff.rd_addr_ff; // read path addresses the array
            // read data, clocked out on the rising edge
            case (st_ff.mode_ff)
                sync_flash_pkg::RM_ID: // [RL20]
                    nxt_st.dq_out_ff = lane_fit((width_select ? st_ff.rd_addr_ff[1]
                                                              : st_ff.rd_addr_ff[0])
                                                ? `DEV_CODE : `MFG_CODE, 1'b1, 1'b0);
                sync_flash_pkg::RM_STATUS:
                    nxt_st.dq_out_ff = {8'h00, (st_ff.wsm_ff != sync_flash_pkg::WS_BUSY),
                                        (st_ff.wsm_ff == sync_flash_pkg::WS_SUSPEND),
                                        1'b0, st_ff.fault_ff, 4'h0};
                default:
                    // byte select dropped in word mode, in byte mode the low bit picks the high or low byte
                    nxt_st.dq_out_ff = lane_fit(arr_rdata, width_select,
                                                st_ff.rd_addr_ff[0]); // [RL11] [RL12]
            endcase
            // output drivers: read needs select, enable and strobe high
            nxt_st.lower_oe_n_ff = !(sel && !output_enable_n && write_strobe_n); // [RL14] [RL15]
            nxt_st.upper_oe_n_ff = nxt_st.lower_oe_n_ff || !width_select; // [RL11]
            // pull-down only while busy, whatever the enables say
            nxt_st.rb_oe_n_ff = (nxt_st.wsm_ff != sync_flash_pkg::WS_BUSY); // [RL5] [RL6] [RL7]
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            st_ff <= idle_state(); // [RL17]
        else
            st_ff <= nxt_st;
    end

    // ==========================================================
    // outputs straight from flops, except ready_busy_n_out which is tied low
    assign data_out              = st_ff.dq_out_ff;
    assign lower_data_lanes_oe_n = st_ff.lower_oe_n_ff;
    assign upper_data_lanes_oe_n = st_ff.upper_oe_n_ff;
    assign ready_busy_n_out      = 1'b0; // open drain: only ever pulls low
    assign ready_busy_n_oe_n     = st_ff.rb_oe_n_ff;
    assign arr_addr              = st_ff.arr_addr_ff;
    assign arr_wdata             = st_ff.arr_wdata_ff;
    assign arr_wr                = st_ff.arr_wr_ff;
    assign arr_erase             = st_ff.arr_erase_ff;
    assign write_fault           = st_ff.fault_ff;

    // ==========================================================
    // assertions
    default clocking dflt_cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    addr_latch_a: assert property (sel && write_strobe_n && !address_strobe_n // [RL1] [RL12]
        && powerdown_reset_n |=> st_ff.rd_addr_ff == $past({addr[`ADDR_W-1:1],
        addr[0] && !width_select})) else $error("read address not latched");
    strobe_ignore_a: assert property (!write_strobe_n && powerdown_reset_n // [RL4]
        |=> $stable(st_ff.rd_addr_ff)) else $error("address latched during write");
    no_latch_a: assert property (address_strobe_n && powerdown_reset_n // [RL13]
        |=> st_ff.rd_addr_ff == $past(st_ff.rd_addr_ff)) else $error("latch without strobe");
    busy_pull_a: assert property (st_ff.wsm_ff == sync_flash_pkg::WS_BUSY // [RL5]
        |-> !ready_busy_n_oe_n) else $error("busy not pulled low");
    ready_rel_a: assert property (!powerdown_reset_n |=> ready_busy_n_oe_n && // [RL6]
        lower_data_lanes_oe_n && upper_data_lanes_oe_n) else $error("power-down outputs");
    lock_block_a: assert property (we_rise && blocked && powerdown_reset_n && // [RL8]
        st_ff.wsm_ff == sync_flash_pkg::WS_PROG_SETUP |=> write_fault && !arr_wr)
        else $error("locked write");
    wp_open_a: assert property (we_rise && st_ff.wp_ff && powerdown_reset_n && // [RL9]
        st_ff.wsm_ff == sync_flash_pkg::WS_PROG_SETUP |=> arr_wr)
        else $error("unlocked write refused");
    byte_float_a: assert property (powerdown_reset_n && !width_select // [RL11]
        |=> upper_data_lanes_oe_n) else $error("upper lanes driven in byte mode");
    read_drive_a: assert property (sel && !output_enable_n && write_strobe_n // [RL14]
        && powerdown_reset_n |=> !lower_data_lanes_oe_n) else $error("read not driven");
    prog_time_a: assert property (arr_wr |-> ##(`PROG_CYCLES) ready_busy_n_oe_n || // [RL5]
        !powerdown_reset_n) else $error("program time wrong");

    prog_cov_c: cover property (arr_wr);
    erase_cov_c: cover property (arr_erase);
    suspend_cov_c: cover property (st_ff.wsm_ff == sync_flash_pkg::WS_SUSPEND);
    fault_cov_c: cover property ($rose(write_fault));

endmodule
`default_nettype wire

// *** sim/array_core_model.sv ***
/*
 * behavioural array core at the far side of the bus interface.
 * assumes arr_addr comes from the design; answers combinationally.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sync_flash_params.svh"

module array_core_model #(
    parameter logic [15:0] LOCKS = 16'h00f0 // blocks 4 to 7 locked
) (
    // request side
    input  wire logic [`ADDR_W-1:0] arr_addr,
    // answer side
    output logic      [`DATA_W-1:0] arr_rdata,
    output logic      [15:0]        block_lock_status_bit
);
    // ==========================================================
    // read word is a pattern of the address, so the bench can predict it
    // limitation: programming is not stored, the bench checks the pulses, address and write data only
    assign arr_rdata = arr_addr[15:0] ^ 16'h3c5a;
    // lock bits stay fixed for the whole run
    assign block_lock_status_bit = LOCKS;
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
/*
 * self-checking bench for the synchronous flash bus interface.
 * assumes the array core model and the design file; inputs move on negedge.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sync_flash_params.svh"

module testbench;
    // ==========================================================
    // pins
    logic ref_clk = 1'b0, nrst = 1'b0, powerdown_reset_n = 1'b1;
    logic chip_select0_n = 1'b0, chip_select1_n = 1'b0, output_enable_n = 1'b1;
    logic write_strobe_n = 1'b1, address_strobe_n = 1'b1;
    logic width_select = 1'b1, write_protect_n = 1'b1;
    logic [20:0] addr = 21'h0;
    logic [15:0] data_in = 16'h0, data_out, arr_rdata, locks, arr_wdata;
    logic [20:0] arr_addr;
    logic lo_oe_n, up_oe_n, rb_out, rb_oe_n, arr_wr, arr_erase, write_fault;
    int mismatches = 0, tests_run = 0, seed = 14, n;
    logic [20:0] a;
    logic [15:0] d;

    always #12.5 ref_clk = ~ref_clk; // 40 MHz

    sync_flash_bus_interface dut (.ref_clk(ref_clk), .nrst(nrst),
        .powerdown_reset_n(powerdown_reset_n), .chip_select0_n(chip_select0_n),
        .chip_select1_n(chip_select1_n), .output_enable_n(output_enable_n),
        .write_strobe_n(write_strobe_n), .address_strobe_n(address_strobe_n),
        .width_select(width_select), .write_protect_n(write_protect_n),
        .addr(addr), .data_in(data_in), .data_out(data_out),
        .lower_data_lanes_oe_n(lo_oe_n), .upper_data_lanes_oe_n(up_oe_n),
        .ready_busy_n_out(rb_out), .ready_busy_n_oe_n(rb_oe_n),
        .arr_rdata(arr_rdata), .block_lock_status_bit(locks),
        .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_wr(arr_wr),
        .arr_erase(arr_erase), .write_fault(write_fault));
    array_core_model core (.arr_addr(arr_addr), .arr_rdata(arr_rdata),
        .block_lock_status_bit(locks));

    // ==========================================================
    // helpers
    function automatic logic [15:0] pat(input logic [20:0] x);
        // core pattern; bit 0 only reaches the low byte, which x8 picks only when it is 0
        return {x[15:1], 1'b0} ^ 16'h3c5a;
    endfunction
    task automatic tick;
        @(negedge ref_clk);
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            mismatches++;
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // write cycle with output enable high, strobe pulsed low
    task automatic bus_write(input logic [20:0] wa, input logic [15:0] wd);
        addr = wa;
        data_in = wd;
        output_enable_n = 1'b1;
        write_strobe_n = 1'b0;
        tick;
        write_strobe_n = 1'b1;
        tick; // pulse of the taken write stands for this one cycle only
    endtask
    // latch a read address, data lands two edges later
    task automatic read(input logic [20:0] ra);
        addr = ra;
        output_enable_n = 1'b0;
        address_strobe_n = 1'b0;
        tick;
        address_strobe_n = 1'b1;
        tick;
        tick;
    endtask
    // count busy cycles; bounded so a stuck pin ends the run
    task automatic wait_ready(output int cnt);
        cnt = 0;
        while (rb_oe_n === 1'b0)
        begin
            cnt++;
            tick;
            if (cnt > 200)
            begin
                mismatches++;
                results;
            end
        end
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (10) tick;
        nrst = 1'b1;
        tick;
        check("rb_oe_n rst", rb_oe_n, 1'b1);
        check("write_fault rst", write_fault, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            a = 21'($random(seed));
            read(a);
            check("x16 data", data_out, pat(a));
            check("up_oe_n x16", up_oe_n, 1'b0);
            check("lo_oe_n read", lo_oe_n, 1'b0);
        end
        addr = ~a;
        repeat (3) tick;
        check("no latch", data_out, pat(a));
        width_select = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            a = {20'($random(seed)), i[0]};
            read(a);
            d = pat(a);
            check("x8 byte", data_out[7:0], a[0] ? d[15:8] : d[7:0]);
            check("up_oe_n x8", up_oe_n, 1'b1);
        end
        width_select = 1'b1;
        output_enable_n = 1'b1;
        repeat (2) tick;
        check("lo_oe_n oe off", lo_oe_n, 1'b1);
        output_enable_n = 1'b0;
        chip_select1_n = 1'b1;
        repeat (2) tick;
        check("lo_oe_n desel", lo_oe_n, 1'b1);
        chip_select1_n = 1'b0;
        // program an unlocked block
        d = 16'($random(seed));
        bus_write(21'h0, 16'h0040);
        bus_write(21'h21abc, d);
        check("arr_wr", arr_wr, 1'b1);
        check("arr_addr", arr_addr, 21'h21abc);
        check("arr_wdata", arr_wdata, d);
        check("rb_out", rb_out, 1'b0);
        chip_select0_n = 1'b1;
        tick;
        check("rb_oe_n desel", rb_oe_n, 1'b0);
        chip_select0_n = 1'b0;
        wait_ready(n);
        check("busy cycles", n + 1, `PROG_CYCLES);
        // locked block refused, then allowed with protect high
        write_protect_n = 1'b0;
        tick;
        bus_write(21'h0, 16'h0040);
        bus_write(21'ha0000, d);
        check("arr_wr locked", arr_wr, 1'b0);
        tick;
        check("write_fault", write_fault, 1'b1);
        bus_write(21'h0, 16'h0070);
        read(21'h0);
        check("status fault", data_out, 16'h0090);
        bus_write(21'h0, 16'h0050);
        tick;
        check("fault clear", write_fault, 1'b0);
        write_protect_n = 1'b1;
        repeat (2) tick;
        bus_write(21'h0, 16'h0010);
        bus_write(21'ha0000, d);
        check("arr_wr unlocked", arr_wr, 1'b1);
        wait_ready(n);
        // identifier codes
        bus_write(21'h0, 16'h0090);
        read(21'h0);
        check("maker code", data_out, `MFG_CODE);
        read(21'h2);
        check("device code", data_out, `DEV_CODE);
        // address strobe during a write cycle is ignored
        bus_write(21'h0, 16'h00ff);
        a = 21'($random(seed));
        read(a);
        addr = ~a;
        address_strobe_n = 1'b0;
        write_strobe_n = 1'b0;
        data_in = 16'h00ff;
        tick;
        write_strobe_n = 1'b1;
        address_strobe_n = 1'b1;
        repeat (3) tick;
        check("strobe in write", data_out, pat(a));
        // erase, suspend, resume, then power-down abort
        bus_write(21'h0, 16'h0020);
        bus_write(21'h40000, 16'h00d0);
        check("arr_erase", arr_erase, 1'b1);
        check("rb_oe_n erase", rb_oe_n, 1'b0);
        repeat (20) tick;
        bus_write(21'h0, 16'h00b0);
        tick;
        check("rb_oe_n suspend", rb_oe_n, 1'b1);
        bus_write(21'h0, 16'h00d0);
        check("rb_oe_n resume", rb_oe_n, 1'b0);
        powerdown_reset_n = 1'b0;
        repeat (2) tick;
        check("rb_oe_n pd", rb_oe_n, 1'b1);
        check("lo_oe_n pd", lo_oe_n, 1'b1);
        powerdown_reset_n = 1'b1;
        tick;
        read(a);
        check("array after pd", data_out, pat(a));
        results;
    end
endmodule
`default_nettype wire
